/* File: hw/srsu_chnorm.sv */
// Received character normaliser: strips parity, folds case, classifies.
// Assumes a byte from the bus with bit 7 as parity.
`timescale 1ns/10ps
module srsu_chnorm (
	input wire logic [7:0] raw,
	output logic [6:0] ch,
	output logic is_term,
	output logic is_digit,
	output logic is_alpha
);

	wire [6:0] low7 = raw[6:0]; // RULE_16
	wire is_lower = (low7 >= srsu_pkg::CH_LA) && (low7 <= srsu_pkg::CH_LZ);

	assign ch = is_lower ? (low7 & ~srsu_pkg::CASE_BIT) : low7; // RULE_14
	assign is_alpha = (ch >= srsu_pkg::CH_UA) && (ch <= srsu_pkg::CH_UZ);
	assign is_digit = (ch >= srsu_pkg::CH_ZERO) && (ch <= srsu_pkg::CH_NINE);
	// CR and LF also end a command so a line end never leaves one pending
	assign is_term = (ch == srsu_pkg::CH_SPACE) || (ch == srsu_pkg::CH_COMMA) ||
		(ch == srsu_pkg::CH_SEMI) || (ch == srsu_pkg::CH_CR) ||
		(ch == srsu_pkg::CH_LF); // RULE_15

endmodule // srsu_chnorm

/* File: hw/srsu_fmt.sv */
// Measurement text serialiser with valid/ready handshake.
// Assumes digits arrive as packed BCD, most significant first.
`timescale 1ns/10ps
module srsu_fmt #(
	parameter int NBLANK = 2,
	parameter int JDIG = 1,
	parameter int KDIG = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] alpha,
	input wire logic neg,
	input wire logic [(JDIG+KDIG)*4-1:0] bcd,
	input wire logic eneg,
	input wire logic [3:0] edig,
	input wire logic ready,
	output logic [7:0] ch_q,
	output logic valid_q,
	output logic done_q
);

	localparam int LEN = NBLANK + JDIG + KDIG + 8;
	localparam int P_SIGN = NBLANK + 1;
	localparam int P_POINT = P_SIGN + JDIG + 1;
	localparam int P_E = P_POINT + KDIG + 1;

	logic [7:0] idx_q, idx_d;
	logic [7:0] alpha_q;
	logic neg_q, eneg_q;
	logic [(JDIG+KDIG)*4-1:0] bcd_q;
	logic [3:0] edig_q;

	function automatic logic [7:0] char_at(input logic [7:0] i, input logic [7:0] a,
		input logic n, input logic [(JDIG+KDIG)*4-1:0] b, input logic en,
		input logic [3:0] ed);
		int d;
		d = 0;
		char_at = {1'b0, srsu_pkg::CH_SPACE};
		if (i == 8'h00) begin
			char_at = a;
		end else if (i == 8'(P_SIGN) || i == 8'(P_E + 1)) begin
			char_at = {1'b0, ((i == 8'(P_SIGN)) ? n : en) ? srsu_pkg::CH_MINUS
				: srsu_pkg::CH_PLUS};
		end else if (i == 8'(P_POINT)) begin
			char_at = {1'b0, srsu_pkg::CH_POINT};
		end else if (i == 8'(P_E)) begin
			char_at = {1'b0, srsu_pkg::CH_E};
		end else if (i == 8'(P_E + 2)) begin
			char_at = {4'h3, ed};
		end else if (i == 8'(P_E + 3)) begin
			char_at = {1'b0, srsu_pkg::CH_CR};
		end else if (i == 8'(P_E + 4)) begin
			char_at = {1'b0, srsu_pkg::CH_LF};
		end else if (i > 8'(P_SIGN)) begin
			d = (i < 8'(P_POINT)) ? int'(i) - P_SIGN - 1 : int'(i) - P_POINT - 1 + JDIG;
			char_at = {4'h3, b[(JDIG+KDIG-1-d)*4 +: 4]};
		end
	endfunction

	wire advance = valid_q && ready;
	wire last = (idx_q == 8'(LEN - 1));
	wire go = start && !valid_q;
	assign idx_d = go ? 8'h00 : 8'(idx_q + 8'h01);

	// RULE_17
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			idx_q <= 8'h00;
			valid_q <= 1'b0;
			done_q <= 1'b0;
			ch_q <= 8'h00;
		end else begin
			done_q <= advance && last;
			if (go || (advance && !last)) begin
				idx_q <= idx_d;
				valid_q <= 1'b1;
				ch_q <= go ? char_at(8'h00, alpha, neg, bcd, eneg, edig)
					: char_at(idx_d, alpha_q, neg_q, bcd_q, eneg_q, edig_q);
			end else if (advance) begin
				valid_q <= 1'b0;
			end
		end
	end

	// Reading is latched so the text stays consistent while it drains
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			alpha_q <= 8'h00;
			neg_q <= 1'b0;
			bcd_q <= '0;
			eneg_q <= 1'b0;
			edig_q <= 4'h0;
		end else if (go) begin
			alpha_q <= alpha;
			neg_q <= neg;
			bcd_q <= bcd;
			eneg_q <= eneg;
			edig_q <= edig;
		end
	end

endmodule // srsu_fmt

/* File: hw/srsu_pkg.sv */
// Constants shared by the status, command and output-format logic.
// Assumes one 10 MHz system clock and a synchronous active-high reset.
package srsu_pkg;

	// ----------------------------------------
	// Status byte bit positions
	// ----------------------------------------
	localparam int ST_DREADY = 0;
	localparam int ST_ERROR = 2;
	localparam int ST_LOCAL = 4;
	localparam int ST_POWER = 5;
	localparam int ST_PEND = 6;
	localparam int MASK_W = 5;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [4:0] MASK_RST = 5'h00;
	localparam logic [2:0] FUNC_RST = 3'h1;

	// ----------------------------------------
	// Function codes accepted by the select command
	// ----------------------------------------
	localparam logic [11:0] FUNC_FIRST = 12'h001;
	localparam logic [11:0] FUNC_LAST = 12'h004;
	localparam logic [11:0] ARG_SAT = 12'hFFF;

	// ----------------------------------------
	// Characters
	// ----------------------------------------
	localparam logic [6:0] CH_SPACE = 7'h20;
	localparam logic [6:0] CH_COMMA = 7'h2C;
	localparam logic [6:0] CH_SEMI = 7'h3B;
	localparam logic [6:0] CH_CR = 7'h0D;
	localparam logic [6:0] CH_LF = 7'h0A;
	localparam logic [6:0] CH_ZERO = 7'h30;
	localparam logic [6:0] CH_NINE = 7'h39;
	localparam logic [6:0] CH_UA = 7'h41;
	localparam logic [6:0] CH_UZ = 7'h5A;
	localparam logic [6:0] CH_LA = 7'h61;
	localparam logic [6:0] CH_LZ = 7'h7A;
	localparam logic [6:0] CASE_BIT = 7'h20;
	localparam logic [6:0] CH_PLUS = 7'h2B;
	localparam logic [6:0] CH_MINUS = 7'h2D;
	localparam logic [6:0] CH_POINT = 7'h2E;
	localparam logic [6:0] CH_E = 7'h45;

	// Two-letter command words, upper case
	localparam logic [13:0] CMD_MASK_LOAD = {7'h53, 7'h4D};
	localparam logic [13:0] CMD_FUNC_SEL = {7'h46, 7'h55};

endpackage

/* File: hw/srsu_top.sv */
// Service request and status unit of a bus-controlled frequency counter.
// Holds the command parser, the enable mask, the status byte, the
// service request and the serial-poll answer; drives the text serialiser.
// Assumes bus bytes, poll and talk requests are one-cycle pulses on clk_sys.
//
// Contract
// RULE_01: Service request line asserts only while the instrument is remote.
// RULE_02: Mask can enable any mix of data ready, error, local, or none.
// RULE_03: Status bit 0 set while a finished reading awaits collection.
// RULE_04: Status bit 2 set while an error or failure is present.
// RULE_05: Status bit 4 set whenever the instrument is local.
// RULE_06: Bit 6 shows pending request, bit 5 power on; neither maskable.
// RULE_07: Condition bits follow their conditions whatever the mask says.
// RULE_08: Request raised when a condition sets with its mask bit set.
// RULE_09: Mask-load command converts its decimal argument into the mask.
// RULE_10: Arguments 0 to 255 accepted; only five low bits kept.
// RULE_11: Mask of zero disables all requests, status bits unchanged.
// RULE_12: Controller loads the mask before the condition it wants reported.
// RULE_13: Status byte readable by serial poll at any time.
// RULE_14: Command letters accepted in either case, treated alike.
// RULE_15: Space, comma and semicolon end the preceding command.
// RULE_16: Parity bit of every received character is ignored.
// RULE_17: Output text: alpha, blanks, sign, digits, point, digits, E, sign, digit, CR LF.
// RULE_18: Illegal function-select argument sets the error condition.
// RULE_19: Status bits 1, 3 and 7 always read zero.
`timescale 1ns/10ps
module srsu_top #(
	parameter int NBLANK = 2,
	parameter int JDIG = 1,
	parameter int KDIG = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] rx_char,
	input wire logic rx_valid,
	input wire logic rx_end,
	input wire logic remote,
	input wire logic meas_done,
	input wire logic fault,
	input wire logic dev_clear,
	input wire logic poll_req,
	input wire logic talk_start,
	input wire logic [7:0] meas_alpha,
	input wire logic meas_neg,
	input wire logic [(JDIG+KDIG)*4-1:0] meas_bcd,
	input wire logic exp_neg,
	input wire logic [3:0] exp_digit,
	input wire logic tx_ready,
	output logic srq_q,
	output logic [7:0] poll_byte_q,
	output logic poll_ack_q,
	output logic [2:0] func_sel_q,
	output logic [4:0] mask_q,
	output logic error_q,
	output logic [7:0] tx_char,
	output logic tx_valid,
	output logic tx_done
);

	// ----------------------------------------
	// Parser states
	// ----------------------------------------
	typedef enum logic [1:0] {
		SRSU_IDLE,
		SRSU_LET2,
		SRSU_ARG,
		SRSU_SKIP
	} srsu_pstate_t;

	srsu_pstate_t pst_q, pst_d;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Decimal accumulate with saturation; oversized arguments stay large
	function automatic logic [11:0] dec_push(input logic [11:0] acc, input logic [3:0] d);
		logic [15:0] wide;
		wide = 16'({4'h0, acc} * 16'h000A) + 16'({12'h000, d});
		dec_push = (wide > 16'({4'h0, srsu_pkg::ARG_SAT})) ? srsu_pkg::ARG_SAT
			: wide[11:0];
	endfunction

	// One flag placed at its own bit of the status byte;
	// keeps every field of the byte built the same way
	function automatic logic [7:0] at_bit(input logic v, input int pos);
		logic [7:0] one;
		one = 8'h00;
		one[pos] = v;
		at_bit = one;
	endfunction

	// ----------------------------------------
	// Character classification
	// ----------------------------------------
	logic [6:0] rx_norm;
	logic rx_term, rx_digit, rx_alpha;

	srsu_chnorm u_chnorm (
		.raw(rx_char),
		.ch(rx_norm),
		.is_term(rx_term),
		.is_digit(rx_digit),
		.is_alpha(rx_alpha)
	);

	// ----------------------------------------
	// Command word and argument
	// ----------------------------------------
	logic [6:0] let1_q, let1_d;
	logic [13:0] word_q, word_d;
	logic [11:0] arg_q, arg_d;
	logic has_arg_q, has_arg_d;

	wire in_arg = (pst_q == SRSU_ARG);
	// A letter straight after an argument starts the next command
	wire end_cmd = in_arg && ((rx_valid && (rx_term || rx_alpha)) || rx_end); // RULE_15

	// ----------------------------------------
	// Command execution
	// ----------------------------------------
	wire word_is_mask = (word_q == srsu_pkg::CMD_MASK_LOAD);
	wire word_is_func = (word_q == srsu_pkg::CMD_FUNC_SEL);
	// An empty mask command leaves the mask alone
	wire exec_mask = end_cmd && word_is_mask && has_arg_q;
	wire exec_func = end_cmd && word_is_func;
	// A missing argument counts as illegal, like an out-of-range code
	wire func_legal = has_arg_q && (arg_q >= srsu_pkg::FUNC_FIRST) &&
		(arg_q <= srsu_pkg::FUNC_LAST);
	wire func_bad = exec_func && !func_legal; // RULE_18

	always_comb begin
		pst_d = pst_q;
		let1_d = let1_q;
		word_d = word_q;
		arg_d = arg_q;
		has_arg_d = has_arg_q;
		if (rx_end && !rx_valid) begin
			pst_d = SRSU_IDLE;
		end else if (rx_valid) begin
			unique case (pst_q)
				SRSU_IDLE: begin
					if (rx_alpha) begin
						let1_d = rx_norm;
						pst_d = SRSU_LET2;
					end else if (!rx_term) begin
						pst_d = SRSU_SKIP;
					end
				end
				SRSU_LET2: begin
					if (rx_alpha) begin
						word_d = {let1_q, rx_norm};
						arg_d = 12'h000;
						has_arg_d = 1'b0;
						pst_d = SRSU_ARG;
					end else begin
						pst_d = rx_term ? SRSU_IDLE : SRSU_SKIP;
					end
				end
				SRSU_ARG: begin
					if (rx_digit) begin
						arg_d = dec_push(arg_q, rx_norm[3:0]); // RULE_09
						has_arg_d = 1'b1;
					end else if (rx_alpha) begin
						let1_d = rx_norm;
						pst_d = SRSU_LET2;
					end else begin
						pst_d = rx_term ? SRSU_IDLE : SRSU_SKIP;
					end
				end
				SRSU_SKIP: begin
					if (rx_term) begin
						pst_d = SRSU_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pst_q <= SRSU_IDLE;
			let1_q <= 7'h00;
			word_q <= 14'h0000;
			arg_q <= 12'h000;
			has_arg_q <= 1'b0;
		end else begin
			pst_q <= pst_d;
			let1_q <= let1_d;
			word_q <= word_d;
			arg_q <= arg_d;
			has_arg_q <= has_arg_d;
		end
	end

	// ----------------------------------------
	// Enable mask and function select
	// ----------------------------------------
	// Values up to 255 and beyond all load; only the low five bits are kept
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mask_q <= srsu_pkg::MASK_RST;
		end else if (exec_mask) begin
			mask_q <= arg_q[srsu_pkg::MASK_W-1:0]; // RULE_10
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			func_sel_q <= srsu_pkg::FUNC_RST;
		end else if (exec_func && func_legal) begin
			func_sel_q <= arg_q[2:0];
		end
	end

	// ----------------------------------------
	// Conditions
	// ----------------------------------------
	logic dready_q;
	logic fmt_done;

	// New reading wins over a collection finishing in the same cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dready_q <= 1'b0;
		end else if (meas_done) begin
			dready_q <= 1'b1; // RULE_03
		end else if (fmt_done || dev_clear) begin
			dready_q <= 1'b0;
		end
	end

	// Device clear removes the error; a new bad code in that cycle keeps it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			error_q <= 1'b0;
		end else if (func_bad) begin
			error_q <= 1'b1; // RULE_18
		end else if (dev_clear) begin
			error_q <= 1'b0;
		end
	end

	wire err_now = error_q || fault; // RULE_04
	wire local_now = !remote; // RULE_05

	// ----------------------------------------
	// Status byte fields
	// ----------------------------------------
	// Bits 1, 3 and 7 have no source and so always read zero
	wire [7:0] dready_bit = at_bit(dready_q, srsu_pkg::ST_DREADY); // RULE_03
	wire [7:0] err_bit = at_bit(err_now, srsu_pkg::ST_ERROR); // RULE_04
	wire [7:0] local_bit = at_bit(local_now, srsu_pkg::ST_LOCAL); // RULE_05

	// Status conditions never pass through the mask
	logic [7:0] cond;
	assign cond = dready_bit | err_bit | local_bit; // RULE_07

	// ----------------------------------------
	// Service request
	// ----------------------------------------
	logic [7:0] cond_prev_q;
	logic pend_q, pend_d;

	wire [4:0] masked_cond = cond[4:0] & mask_q; // RULE_02
	// Only a fresh condition counts; mask set later does not look back
	wire [4:0] rise = masked_cond & ~cond_prev_q[4:0]; // RULE_08
	wire poll_take = poll_req;

	// A rise in the poll cycle keeps the request pending
	assign pend_d = (|rise) ? 1'b1 : (poll_take ? 1'b0 : pend_q); // RULE_11

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cond_prev_q <= 8'h00;
			pend_q <= 1'b0;
		end else begin
			cond_prev_q <= cond;
			pend_q <= pend_d;
		end
	end

	// ----------------------------------------
	// Request line
	// ----------------------------------------
	// Going local hides the line, but the request stays pending
	// and shows again on return to remote if not polled first
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			srq_q <= 1'b0;
		end else begin
			srq_q <= pend_d && remote; // RULE_01
		end
	end

	// ----------------------------------------
	// Serial poll answer
	// ----------------------------------------
	wire [7:0] pend_bit = at_bit(pend_q, srsu_pkg::ST_PEND); // RULE_06
	// Power-on reads one whenever the logic is clocked at all
	wire [7:0] status_byte = cond | pend_bit | at_bit(1'b1, srsu_pkg::ST_POWER); // RULE_06 RULE_19

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			poll_ack_q <= 1'b0;
		end else begin
			poll_ack_q <= poll_take;
		end
	end

	// Byte is frozen at the poll so a slow reader sees one sample
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			poll_byte_q <= 8'h00;
		end else if (poll_take) begin
			poll_byte_q <= status_byte; // RULE_13
		end
	end

	// ----------------------------------------
	// Measurement text
	// ----------------------------------------
	srsu_fmt #(
		.NBLANK(NBLANK),
		.JDIG(JDIG),
		.KDIG(KDIG)
	) u_fmt (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(talk_start),
		.alpha(meas_alpha),
		.neg(meas_neg),
		.bcd(meas_bcd),
		.eneg(exp_neg),
		.edig(exp_digit),
		.ready(tx_ready),
		.ch_q(tx_char),
		.valid_q(tx_valid),
		.done_q(fmt_done)
	);

	// Done is already a flop inside the serialiser, so no extra lag
	assign tx_done = fmt_done;

endmodule // srsu_top

/* File: sim/srsu_host.sv */
// Bus controller model: sends command text, polls, takes measurement text.
// Assumes the unit samples its inputs on the rising edge of clk_sys.
`timescale 1ns/10ps
module srsu_host (
	input wire logic clk_sys,
	input wire logic [7:0] poll_byte_q,
	input wire logic [7:0] tx_char,
	input wire logic tx_valid,
	output logic [7:0] rx_char,
	output logic rx_valid,
	output logic rx_end,
	output logic poll_req,
	output logic tx_ready
);
	logic [7:0] rxq[$];
	logic par = 1'b0;
	int cnt = 0;
	initial begin
		rx_char = 8'h00;
		rx_valid = 1'b0;
		rx_end = 1'b0;
		poll_req = 1'b0;
		tx_ready = 1'b0;
	end
	// Sink stalls two cycles in five
	always @(posedge clk_sys) begin
		cnt <= cnt + 1;
		tx_ready <= (cnt % 5) > 1;
		if (tx_valid && tx_ready)
			rxq.push_back(tx_char);
	end
	task send(input string s, input logic fin);
		byte c;
		for (int i = 0; i < s.len(); i++) begin
			c = s[i];
			@(posedge clk_sys);
			par = ~par;
			rx_char <= {par, c[6:0]};
			rx_valid <= 1'b1;
		end
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		// Idle data is scrambled, not left at the last byte
		rx_char <= ~rx_char;
		rx_end <= fin;
		@(posedge clk_sys);
		rx_end <= 1'b0;
	endtask
	task poll(output logic [7:0] b);
		@(posedge clk_sys);
		poll_req <= 1'b1;
		@(posedge clk_sys);
		poll_req <= 1'b0;
		#1;
		b = poll_byte_q;
	endtask
endmodule // srsu_host

/* File: sim/srsu_top_asserts.sv */
// Checker for the status unit: poll answer, request line and text port.
// Assumes it is bound into srsu_top and sees only that module's ports.
`timescale 1ns/10ps
module srsu_top_asserts (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic rx_valid,
	input wire logic rx_end,
	input wire logic remote,
	input wire logic fault,
	input wire logic poll_req,
	input wire logic talk_start,
	input wire logic [7:0] meas_alpha,
	input wire logic tx_ready,
	input wire logic srq_q,
	input wire logic [7:0] poll_byte_q,
	input wire logic poll_ack_q,
	input wire logic [4:0] mask_q,
	input wire logic error_q,
	input wire logic [7:0] tx_char,
	input wire logic tx_valid,
	input wire logic tx_done
);
	logic lf_acc;
	// Done follows the final accept by one cycle; the check also allows two
	assign lf_acc = tx_valid && tx_ready && tx_char == 8'h0A;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Status byte and request
	// ----------------------------------------
	a_srq_needs_remote: assert property (srq_q |-> $past(remote))
		else $error("request line high while local");
	a_poll_ack_lag: assert property (poll_ack_q == $past(poll_req))
		else $error("poll answer not one cycle after request");
	a_zero_bits: assert property (poll_ack_q |-> poll_byte_q[7:6] != 2'h3 &&
		!poll_byte_q[7] && !poll_byte_q[3] && !poll_byte_q[1])
		else $error("unassigned status bit set");
	a_power_bit: assert property (poll_ack_q |-> poll_byte_q[5])
		else $error("power bit clear in poll");
	a_local_bit: assert property (poll_ack_q && $past(remote, 2) == $past(remote)
		|-> poll_byte_q[4] == !$past(remote))
		else $error("local bit wrong");
	a_err_bit: assert property (poll_ack_q && ($past(error_q) ||
		$past(fault, 2) && $past(fault)) |-> poll_byte_q[2])
		else $error("error bit clear while error present");
	a_error_cause: assert property ($rose(error_q) |-> $past(rx_valid) || $past(rx_end))
		else $error("error set without a command");
	a_mask_cause: assert property ($changed(mask_q) |-> $past(rx_valid) || $past(rx_end))
		else $error("mask changed without a command");
	// ----------------------------------------
	// Measurement text
	// ----------------------------------------
	a_tx_first: assert property (talk_start && !tx_valid |=>
		tx_valid && tx_char == $past(meas_alpha))
		else $error("text does not open with alpha");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
		else $error("text char dropped while stalled");
	a_tx_done_cause: assert property (tx_done |-> $past(lf_acc) || $past(lf_acc, 2))
		else $error("done without line feed accepted");
	c_srq: cover property ($rose(srq_q));
	c_poll_pend: cover property (poll_ack_q && poll_byte_q[6]);
	c_err: cover property ($rose(error_q));
	c_done: cover property (tx_done);
endmodule // srsu_top_asserts

bind srsu_top srsu_top_asserts srsu_top_asserts_i (.clk_sys(clk_sys), .rst(rst),
	.rx_valid(rx_valid), .rx_end(rx_end), .remote(remote), .fault(fault),
	.poll_req(poll_req), .talk_start(talk_start), .meas_alpha(meas_alpha),
	.tx_ready(tx_ready), .srq_q(srq_q), .poll_byte_q(poll_byte_q),
	.poll_ack_q(poll_ack_q), .mask_q(mask_q), .error_q(error_q),
	.tx_char(tx_char), .tx_valid(tx_valid), .tx_done(tx_done));

/* File: sim/tb.sv */
// Top bench: host model, unit under test and the scenario sequence.
// Assumes default serialiser parameters: two blanks, one and eight digits.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
	$display("Error at %0t: got %h exp %h", $time, (a), (b)); end end
module tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic remote = 1'b1;
	logic meas_done = 1'b0;
	logic fault = 1'b0;
	logic dev_clear = 1'b0;
	logic talk_start = 1'b0;
	logic [7:0] meas_alpha = 8'h41;
	logic meas_neg = 1'b0;
	logic [35:0] meas_bcd = 36'h0;
	logic exp_neg = 1'b0;
	logic [3:0] exp_digit = 4'h0;
	logic [7:0] rx_char, poll_byte_q, tx_char, b;
	logic rx_valid, rx_end, poll_req, tx_ready, srq_q, poll_ack_q;
	logic error_q, tx_valid, tx_done;
	logic [2:0] func_sel_q;
	logic [4:0] mask_q;
	logic [31:0] seed = 32'h0000005A;
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;
	always #50 clk_sys = ~clk_sys;
	srsu_host srsu_host_i (.clk_sys(clk_sys), .poll_byte_q(poll_byte_q), .tx_char(tx_char),
		.tx_valid(tx_valid), .rx_char(rx_char), .rx_valid(rx_valid), .rx_end(rx_end),
		.poll_req(poll_req), .tx_ready(tx_ready));
	srsu_top srsu_top_i (.clk_sys(clk_sys), .rst(rst), .rx_char(rx_char), .rx_valid(rx_valid),
		.rx_end(rx_end), .remote(remote), .meas_done(meas_done), .fault(fault),
		.dev_clear(dev_clear), .poll_req(poll_req), .talk_start(talk_start),
		.meas_alpha(meas_alpha), .meas_neg(meas_neg), .meas_bcd(meas_bcd),
		.exp_neg(exp_neg), .exp_digit(exp_digit), .tx_ready(tx_ready), .srq_q(srq_q),
		.poll_byte_q(poll_byte_q), .poll_ack_q(poll_ack_q), .func_sel_q(func_sel_q),
		.mask_q(mask_q), .error_q(error_q), .tx_char(tx_char), .tx_valid(tx_valid),
		.tx_done(tx_done));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] exp_ch(int i);
		if (i == 0) return meas_alpha;
		if (i <= 2) return 8'h20;
		if (i == 3 || i == 15) return ((i == 3) ? meas_neg : exp_neg) ? 8'h2D : 8'h2B;
		if (i == 4) return 8'h30 + meas_bcd[35:32];
		if (i == 5) return 8'h2E;
		if (i <= 13) return 8'h30 + meas_bcd[(13 - i) * 4 +: 4];
		if (i == 14) return 8'h45;
		if (i == 16) return 8'h30 + exp_digit;
		return (i == 17) ? 8'h0D : 8'h0A;
	endfunction
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task pc(input logic [7:0] e);
		srsu_host_i.poll(b);
		`CHK(b, e)
		`CHK(poll_ack_q, 1'b1)
	endtask
	task close_out();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			close_out();
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		int n;
		int k;
		logic [31:0] r;
		string s;
		string tl;
		tl = " ,;";
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		tick(1);
		`CHK(mask_q, srsu_pkg::MASK_RST)
		`CHK(func_sel_q, srsu_pkg::FUNC_RST)
		pc(8'h20);
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			n = (i == 0) ? 0 : (i == 1) ? 255 : int'(rnd() % 256);
			k = int'(rnd() % 4) + 1;
			s = (rnd() & 1) ? "sM" : "Sm";
			s = {s, $sformatf("%0d;fU%0d", n, k)};
			if (i % 4 != 3) s = {s, tl.substr(i % 3, i % 3)};
			srsu_host_i.send(s, i % 4 == 3);
			tick(2);
			`CHK(mask_q, n[4:0])
			`CHK(func_sel_q, k[2:0])
			`CHK(error_q, 1'b0)
		end
		// Skipped token, letter straight after an argument, CR as terminator
		srsu_host_i.send("x9 sm7fu3\015", 1'b0);
		tick(2);
		`CHK(mask_q, 5'h07)
		`CHK(func_sel_q, 3'h3)
		`CHK(error_q, 1'b0)
		$display("test commands done");
		srsu_host_i.send("SM1,", 1'b0);
		meas_done <= 1'b1;
		@(posedge clk_sys);
		meas_done <= 1'b0;
		tick(3);
		`CHK(srq_q, 1'b1)
		pc(8'h61);
		tick(1);
		`CHK(srq_q, 1'b0)
		$display("test request done");
		@(posedge clk_sys);
		r = rnd();
		meas_alpha <= 8'h41 + 8'(r[7:0] % 26);
		meas_neg <= r[0];
		exp_neg <= r[1];
		exp_digit <= 4'(r[15:8] % 10);
		for (int j = 0; j < 9; j++) meas_bcd[j * 4 +: 4] <= 4'(rnd() % 10);
		talk_start <= 1'b1;
		@(posedge clk_sys);
		talk_start <= 1'b0;
		k = 0;
		while (tx_done !== 1'b1 && k < 200) begin
			@(posedge clk_sys);
			k++;
		end
		tick(1);
		`CHK(srsu_host_i.rxq.size(), 19)
		for (int i = 0; i < 19; i++) `CHK(srsu_host_i.rxq[i], exp_ch(i))
		pc(8'h20);
		$display("test text done");
		srsu_host_i.send("sm0 ", 1'b0);
		fault <= 1'b1;
		tick(4);
		`CHK(srq_q, 1'b0)
		pc(8'h24);
		fault <= 1'b0;
		srsu_host_i.send("SM4,FU5,", 1'b0);
		tick(2);
		`CHK(error_q, 1'b1)
		tick(2);
		`CHK(srq_q, 1'b1)
		pc(8'h64);
		dev_clear <= 1'b1;
		tick(1);
		dev_clear <= 1'b0;
		tick(2);
		`CHK(error_q, 1'b0)
		$display("test error done");
		srsu_host_i.send("SM21;", 1'b0);
		remote <= 1'b0;
		tick(4);
		`CHK(srq_q, 1'b0)
		pc(8'h70);
		$display("test local done");
		close_out();
	end
endmodule // tb
